// *** tb/ocdbk_core_props.sv ***
`timescale 1ns/1ps
module ocdbk_core_props
  import ocdbk_pkg::*;
(
  input wire logic clk_i,  // Core clock
  input wire logic rstn_i,  // Reset, active low
  input wire logic fetch_valid_i,  // Fetch slot valid
  input wire logic fetch_is_break_i,  // Break fetched
  input wire logic cpu_run_o,  // Execution enabled
  input wire logic cpu_exec_pending_o,  // Held instruction runs
  input wire logic mem_rd_o,  // Memory read pulse
  input wire logic [ADDR_W-1:0] mem_addr_o  // Memory address
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  // Hits in the pending slot are ignored, so they are left out here.
  sequence s_brk;
    cpu_run_o && !cpu_exec_pending_o && fetch_valid_i && fetch_is_break_i;
  endsequence
  sequence s_rd;
    mem_rd_o ##1 !mem_rd_o;
  endsequence
  a_break_halts: assert property (s_brk |=> !cpu_run_o) else $error("no halt");
  a_resume_pend: assert property ($rose(cpu_run_o) |-> cpu_exec_pending_o) else $error("resume");
  a_pend_pulse: assert property (cpu_exec_pending_o |=> !cpu_exec_pending_o) else $error("pend");
  a_pend_runs: assert property (cpu_exec_pending_o |-> cpu_run_o) else $error("pend run");
  a_pend_halted: assert property ($rose(cpu_exec_pending_o) |-> !$past(cpu_run_o)) else $error("pe");
  a_rd_pulse: assert property (mem_rd_o |-> s_rd) else $error("read pulse");
  a_rd_halted: assert property (mem_rd_o |-> !cpu_run_o) else $error("read while run");
  a_rd_addr: assert property (mem_rd_o |=> $stable(mem_addr_o)) else $error("read addr");
endmodule
bind ocdbk_core ocdbk_core_props u_props (.clk_i(clk_i), .rstn_i(rstn_i),
  .fetch_valid_i(fetch_valid_i), .fetch_is_break_i(fetch_is_break_i), .cpu_run_o(cpu_run_o),
  .cpu_exec_pending_o(cpu_exec_pending_o), .mem_rd_o(mem_rd_o), .mem_addr_o(mem_addr_o));

// *** tb/ocdbk_probe.sv ***
`timescale 1ns/1ps
module ocdbk_probe (
  output logic tck_o,  // Test clock, still between frames
  output logic tms_o,  // Mode select
  output logic tdi_o,  // Data toward target
  output logic trst_n_o,  // Test reset, active low, driven both high and low
  output logic active_o,  // Activity indicator
  input wire logic tdo_i  // Data from target
);
  initial {tck_o, tms_o, tdi_o, trst_n_o, active_o} = 5'h08;
  // Outside shifting the data line toggles so no stale bit is mistaken for data.
  task automatic tick(input logic m, input logic d, output logic q);
    tms_o = m;
    tdi_o = d;
    #24;
    q = tdo_i;
    tck_o = 1'b1;
    #24;
    tck_o = 1'b0;
  endtask
  task automatic nav(input logic [3:0] p, input int k);
    logic q;
    for (int i = 0; i < k; i++) tick(p[i], ~tdi_o, q);
  endtask
  task automatic link_reset();
    trst_n_o = 1'b0;
    nav(4'h3, 2);
    trst_n_o = 1'b1;
    nav(4'h0, 1);
  endtask
  task automatic scan(input logic [3:0] ir, input logic [39:0] din, input int n,
                      output logic [39:0] dout);
    logic q;
    dout = '0;
    active_o = 1'b1;
    nav(4'h3, 4);
    for (int i = 0; i < 4; i++) tick(i == 3, ir[i], q);
    nav(4'h3, 4);
    for (int i = 0; i < n; i++) begin
      tick(i == n - 1, din[i], q);
      dout[i] = q;
    end
    nav(4'h1, 2);
    active_o = 1'b0;
  endtask
endmodule

// *** tb/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
  import ocdbk_pkg::*;
  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic [ADDR_W-1:0] fpc = '0;
  logic fbrk = 1'b0;
  logic fval = 1'b1;
  logic tck, tms, tdi, trst_n, act, tdo, oe, run, pend, mrd;
  logic [ADDR_W-1:0] maddr, rd_a;
  logic [39:0] rd;
  int fails = 0;
  int total_checks = 0;
  int rd_n = 0;
  int pend_n = 0;
  // A released data-out line floats up to its pull-up level.
  wire tdo_pin = oe ? tdo : 1'b1;
  always #12.5 clk_i = ~clk_i;
  ocdbk_probe probe (.tck_o(tck), .tms_o(tms), .tdi_o(tdi), .trst_n_o(trst_n),
    .active_o(act), .tdo_i(tdo_pin));
  ocdbk_core uut (.clk_i(clk_i), .rstn_i(rstn_i), .tck_i(tck), .tms_i(tms), .tdi_i(tdi),
    .test_reset_n_i(trst_n), .tdo_o(tdo), .tdo_oe_o(oe), .fetch_pc_i(fpc),
    .fetch_valid_i(fval), .fetch_is_break_i(fbrk), .mem_rdata_i(maddr[7:0] ^ 8'ha5),
    .pc_i(fpc ^ 16'h8000), .cpu_run_o(run), .cpu_exec_pending_o(pend), .mem_rd_o(mrd),
    .mem_addr_o(maddr));
  always @(posedge clk_i) begin
    if (mrd === 1'b1) begin
      rd_n <= rd_n + 1;
      rd_a <= maddr;
    end
    if (pend === 1'b1) pend_n <= pend_n + 1;
  end
  task automatic chk(input logic [39:0] g, input logic [39:0] e);
    total_checks++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic close_out();
    if (fails == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  // Eight cycles after each scan cover the crossing latency and the command spacing.
  task automatic sc(input logic [3:0] ir, input logic [39:0] d, input int n);
    probe.scan(ir, d, n, rd);
    cyc(8);
  endtask
  task automatic t_refuse();
    int n0;
    n0 = rd_n;
    sc(IR_MEM, 40'h0333, ADDR_W);
    chk(rd_n, n0);
    sc(IR_CTRL, CMD_STOP, 2);
    chk(run, 1'b0);
    sc(IR_STATUS, '0, STAT_W);
    chk(rd[STAT_HALT], 1'b1);
    sc(IR_MEM, 40'h0333, ADDR_W);
    chk({rd_n - n0, rd_a}, {32'h1, 16'h0333});
    sc(IR_CTRL, CMD_START, 2);
    chk(run, 1'b1);
  endtask
  task automatic t_hw();
    logic [15:0] a;
    int k;
    for (int i = 0; i < NUM_BKPT; i++) begin
      a = {13'h0020, i[2:0]};
      sc(IR_BKPT, {20'h0, 1'b1, i[2:0], a}, BKPT_DR_W);
      fpc = a;
      for (k = 0; k < 40 && run !== 1'b0; k++) cyc(1);
      chk(run, 1'b0);
      fpc = '0;
      sc(IR_STATUS, '0, STAT_W);
      chk(rd, 40'h0b);
      sc(IR_MEM, {24'h0, a}, ADDR_W);
      chk(rd_a, a);
      sc(IR_STATE, '0, STATE_DR_W);
      chk(rd, {a[7:0] ^ 8'ha5, a, a ^ 16'h8000});
      sc(IR_BKPT, {20'h0, 1'b0, i[2:0], a}, BKPT_DR_W);
      sc(IR_CTRL, CMD_START, 2);
      sc(IR_STATUS, '0, STAT_W);
      chk({run, rd}, {1'b1, 40'h0});
    end
  endtask
  task automatic t_sw();
    int p0;
    fpc = 16'h0200;
    fbrk = 1'b1;
    cyc(1);
    fbrk = 1'b0;
    chk(run, 1'b0);
    sc(IR_STATUS, '0, STAT_W);
    chk(rd, 40'h07);
    cyc(20);
    p0 = pend_n;
    chk(run, 1'b0);
    sc(IR_CTRL, CMD_STEP, 2);
    chk({pend_n - p0, run}, {32'h1, 1'b0});
    sc(IR_CTRL, CMD_START, 2);
    chk({pend_n - p0, run}, {32'h2, 1'b1});
  endtask
  initial begin
    cyc(3);
    rstn_i = 1'b1;
    probe.link_reset();
    cyc(2);
    t_refuse();
    t_hw();
    t_sw();
    chk(oe, 1'b0);
    close_out();
  end
  initial begin
    #1000000;
    fails++;
    close_out();
  end
endmodule

// *** verilog/ocdbk_core.sv ***
`timescale 1ns/1ps
// Behaviour
// - After a break, pc, I/O, registers, SRAM and logic boundary are scannable; this core reads out only pc, one memory byte and its address.
// - A break halts instruction execution only; peripherals and I/O clock keep running.
// - Peripheral operations finish during the halt; flags show at next step.
// - A fetched break instruction halts the processor.
// - Resume only on start command; pending instruction executes first.
// - Five hardware breakpoint registers each hold one compare address.
module ocdbk_core
  import ocdbk_pkg::*;
#(
  parameter int NBKPT = NUM_BKPT
) (
  input wire logic clk_i,  // Core clock, 40 MHz
  input wire logic rstn_i,  // Synchronous reset, active low
  input wire logic tck_i,  // Test clock from the probe
  input wire logic tms_i,  // Test mode select
  input wire logic tdi_i,  // Test data in
  input wire logic test_reset_n_i,  // Test reset from probe, active low
  output logic tdo_o,  // Test data out
  output logic tdo_oe_o,  // Test data out driven
  input wire logic [ADDR_W-1:0] fetch_pc_i,  // Address of instruction being fetched
  input wire logic fetch_valid_i,  // Fetch slot presents an instruction
  input wire logic fetch_is_break_i,  // Fetched instruction is a break
  input wire logic [DATA_W-1:0] mem_rdata_i,  // Read data of debug memory access
  input wire logic [ADDR_W-1:0] pc_i,  // Current program counter
  output logic cpu_run_o,  // Instruction execution enabled
  output logic cpu_exec_pending_o,  // Execute the held instruction first
  output logic mem_rd_o,  // Debug memory read pulse
  output logic [ADDR_W-1:0] mem_addr_o  // Debug memory access address
);
  // The compare bank and the status layout assume exactly the documented
  // count, and the index field of the breakpoint word must reach every entry.
  initial begin
    if (NBKPT != NUM_BKPT) begin
      $error("bad breakpoint count");
    end
    if (NBKPT > (1 << BIDX_W)) begin
      $error("breakpoint index field too narrow");
    end
  end

  // ---------------- Link (tck) domain ----------------
  ocdbk_tap_t tap_ff;
  ocdbk_tap_t nxt_tap;
  logic [IR_W-1:0] ir_sh_ff;
  logic [IR_W-1:0] ir_ff;
  // One shift chain serves every data register except bypass; it is as wide as the widest.
  logic [STATE_DR_W-1:0] dr_ff;
  logic bypass_ff;
  logic tdo_ff;
  logic tdo_oe_ff;
  logic [BKPT_DR_W-1:0] bk_upd_ff;
  logic bk_tgl_ff;
  logic [1:0] cmd_upd_ff;
  logic cmd_tgl_ff;
  logic [ADDR_W-1:0] mem_upd_ff;
  logic mem_tgl_ff;
  logic [1:0] st_sync_ff;
  logic [1:0] bk_sync_ff;

  always_comb begin
    case (tap_ff)
      TS_RESET: nxt_tap = tms_i ? TS_RESET : TS_IDLE;
      TS_IDLE: nxt_tap = tms_i ? TS_SEL_DR : TS_IDLE;
      TS_SEL_DR: nxt_tap = tms_i ? TS_SEL_IR : TS_CAP_DR;
      TS_CAP_DR: nxt_tap = tms_i ? TS_EX1_DR : TS_SH_DR;
      TS_SH_DR: nxt_tap = tms_i ? TS_EX1_DR : TS_SH_DR;
      TS_EX1_DR: nxt_tap = tms_i ? TS_UPD_DR : TS_PA_DR;
      TS_PA_DR: nxt_tap = tms_i ? TS_EX2_DR : TS_PA_DR;
      TS_EX2_DR: nxt_tap = tms_i ? TS_UPD_DR : TS_SH_DR;
      TS_UPD_DR: nxt_tap = tms_i ? TS_SEL_DR : TS_IDLE;
      TS_SEL_IR: nxt_tap = tms_i ? TS_RESET : TS_CAP_IR;
      TS_CAP_IR: nxt_tap = tms_i ? TS_EX1_IR : TS_SH_IR;
      TS_SH_IR: nxt_tap = tms_i ? TS_EX1_IR : TS_SH_IR;
      TS_EX1_IR: nxt_tap = tms_i ? TS_UPD_IR : TS_PA_IR;
      TS_PA_IR: nxt_tap = tms_i ? TS_EX2_IR : TS_PA_IR;
      TS_EX2_IR: nxt_tap = tms_i ? TS_UPD_IR : TS_SH_IR;
      TS_UPD_IR: nxt_tap = tms_i ? TS_SEL_DR : TS_IDLE;
      default: nxt_tap = TS_RESET;
    endcase
  end

  // Status and state values cross from the core domain as held words; they
  // are only sampled in capture, after the core has had many cycles to settle.
  logic [STAT_W-1:0] status_core_ff;
  logic [STATE_DR_W-1:0] state_core_ff;
  logic [STAT_W-1:0] st_cap;
  logic st_hold_ok;
  assign st_hold_ok = st_sync_ff[1];
  assign st_cap = st_hold_ok ? status_core_ff : '0;

  wire cap_dr = (tap_ff == TS_CAP_DR);
  wire sh_dr = (tap_ff == TS_SH_DR);
  wire upd_dr = (tap_ff == TS_UPD_DR);
  wire sh_ir = (tap_ff == TS_SH_IR);
  wire upd_ir = (tap_ff == TS_UPD_IR);
  wire ir_bypass = !(ir_ff inside {IR_IDCODE, IR_STATUS, IR_BKPT, IR_CTRL, IR_STATE, IR_MEM});
  wire [5:0] dr_len = (ir_ff == IR_IDCODE) ? 6'h20 :
                      (ir_ff == IR_STATUS) ? 6'h08 :
                      (ir_ff == IR_BKPT) ? 6'(BKPT_DR_W) :
                      (ir_ff == IR_CTRL) ? 6'h02 :
                      (ir_ff == IR_MEM) ? 6'(ADDR_W) : 6'(STATE_DR_W);
  wire [STATE_DR_W-1:0] dr_in = {tdi_i, dr_ff[STATE_DR_W-1:1]};
  // Short registers sit in the top bits of the shared chain, so the captured
  // word is moved up by the same pad that aligns the shifted word back down.
  // Without this the first bits out of a short register would be padding.
  wire [5:0] dr_pad = 6'(STATE_DR_W) - dr_len;
  wire [STATE_DR_W-1:0] dr_al = dr_ff >> dr_pad;
  wire [STATE_DR_W-1:0] cap_val = (ir_ff == IR_IDCODE) ? STATE_DR_W'(IDCODE_VAL) :
                                  (ir_ff == IR_STATUS) ? STATE_DR_W'(st_cap) :
                                  (ir_ff == IR_STATE) ? state_core_ff : '0;

  always_ff @(posedge tck_i) begin
    if (!test_reset_n_i) begin
      tap_ff <= TS_RESET;
      ir_sh_ff <= '0;
      ir_ff <= IR_IDCODE;
      dr_ff <= '0;
      bypass_ff <= 1'b0;
      bk_upd_ff <= '0;
      bk_tgl_ff <= 1'b0;
      cmd_upd_ff <= CMD_NONE;
      cmd_tgl_ff <= 1'b0;
      mem_upd_ff <= '0;
      mem_tgl_ff <= 1'b0;
      st_sync_ff <= '0;
    end else begin
      tap_ff <= nxt_tap;
      st_sync_ff <= {st_sync_ff[0], 1'b1};
      if (tap_ff == TS_RESET) ir_ff <= IR_IDCODE;
      if (tap_ff == TS_CAP_IR) ir_sh_ff <= 4'h1;
      if (sh_ir) ir_sh_ff <= {tdi_i, ir_sh_ff[IR_W-1:1]};
      if (upd_ir) ir_ff <= ir_sh_ff;
      if (cap_dr) dr_ff <= cap_val << dr_pad;
      if (sh_dr) dr_ff <= dr_in;
      bypass_ff <= sh_dr ? tdi_i : 1'b0;
      if (upd_dr && ir_ff == IR_BKPT) begin
        bk_upd_ff <= dr_al[BKPT_DR_W-1:0];
        bk_tgl_ff <= ~bk_tgl_ff;
      end
      if (upd_dr && ir_ff == IR_CTRL) begin
        cmd_upd_ff <= dr_al[1:0];
        cmd_tgl_ff <= ~cmd_tgl_ff;
      end
      if (upd_dr && ir_ff == IR_MEM) begin
        mem_upd_ff <= dr_al[ADDR_W-1:0];
        mem_tgl_ff <= ~mem_tgl_ff;
      end
    end
  end

  // Data out changes on the falling test clock edge, as the test port requires.
  always_ff @(negedge tck_i) begin
    if (!test_reset_n_i) begin
      tdo_ff <= 1'b0;
      tdo_oe_ff <= 1'b0;
    end else begin
      tdo_ff <= sh_ir ? ir_sh_ff[0] : (ir_bypass ? bypass_ff : dr_al[0]);
      tdo_oe_ff <= sh_ir | sh_dr;
    end
  end
  assign tdo_o = tdo_ff;
  assign tdo_oe_o = tdo_oe_ff;

  // ---------------- Core (clk) domain ----------------
  // Each toggle passes two flip-flops before the third gives the edge.
  logic [2:0] bk_tsync_ff;
  logic [2:0] cmd_tsync_ff;
  logic [2:0] mem_tsync_ff;
  logic [ADDR_W-1:0] bk_addr_ff [NBKPT];
  logic [NBKPT-1:0] bk_en_ff;
  ocdbk_run_t run_ff;
  ocdbk_run_t nxt_run;
  logic brk_ff;
  logic swbrk_ff;
  logic hwbrk_ff;
  logic mem_rd_ff;
  logic [ADDR_W-1:0] mem_addr_ff;
  logic [DATA_W-1:0] mem_data_ff;
  logic [ADDR_W-1:0] pc_hold_ff;

  wire bk_evt = bk_tsync_ff[2] ^ bk_tsync_ff[1];
  wire cmd_evt = cmd_tsync_ff[2] ^ cmd_tsync_ff[1];
  wire mem_evt = mem_tsync_ff[2] ^ mem_tsync_ff[1];
  // Command and word change with their toggle and are stable before its synchronised edge is seen.
  wire [1:0] cmd_now = cmd_evt ? cmd_upd_ff : CMD_NONE;
  wire is_start = (cmd_now == CMD_START);
  wire is_step = (cmd_now == CMD_STEP);
  wire is_stop = (cmd_now == CMD_STOP);
  logic [NBKPT-1:0] bk_hit;
  for (genvar g = 0; g < NBKPT; g++) begin : g_cmp
    assign bk_hit[g] = bk_en_ff[g] && (bk_addr_ff[g] == fetch_pc_i);
  end
  wire running = (run_ff == RS_RUN) || (run_ff == RS_STEP);
  wire hw_hit = running && fetch_valid_i && (|bk_hit);
  wire sw_hit = running && fetch_valid_i && fetch_is_break_i;
  wire halt_now = hw_hit || sw_hit || (run_ff == RS_STEP) || is_stop;
  // A break is recorded only from free running; a step that falls back to
  // halt is the planned end of the step and raises no flags.
  wire brk_set = (run_ff == RS_RUN) && halt_now;
  wire sw_set = (run_ff == RS_RUN) && sw_hit;
  wire hw_set = (run_ff == RS_RUN) && hw_hit;

  always_comb begin
    nxt_run = run_ff;
    case (run_ff)
      RS_RUN: begin
        if (halt_now) nxt_run = RS_HALT;
      end
      RS_HALT: begin
        // Only start or step leave halt; any other command is ignored here.
        if (is_start) nxt_run = RS_PEND;
        else if (is_step) nxt_run = RS_STEP;
      end
      RS_PEND: begin
        // The held instruction runs in this slot, so its own break is not
        // taken again; a stop command still wins.
        nxt_run = halt_now ? RS_HALT : RS_RUN;
      end
      RS_STEP: begin
        nxt_run = RS_HALT;
      end
      default: begin
        nxt_run = RS_HALT;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      bk_tsync_ff <= '0;
      cmd_tsync_ff <= '0;
      mem_tsync_ff <= '0;
      bk_en_ff <= '0;
      run_ff <= RS_RUN;
      brk_ff <= 1'b0;
      swbrk_ff <= 1'b0;
      hwbrk_ff <= 1'b0;
      mem_rd_ff <= 1'b0;
      mem_addr_ff <= '0;
      mem_data_ff <= '0;
      pc_hold_ff <= '0;
      status_core_ff <= '0;
      state_core_ff <= '0;
    end else begin
      bk_tsync_ff <= {bk_tsync_ff[1:0], bk_tgl_ff};
      cmd_tsync_ff <= {cmd_tsync_ff[1:0], cmd_tgl_ff};
      mem_tsync_ff <= {mem_tsync_ff[1:0], mem_tgl_ff};
      run_ff <= nxt_run;
      if (bk_evt) begin
        bk_en_ff[bk_upd_ff[ADDR_W +: BIDX_W]] <= bk_upd_ff[BKPT_DR_W-1];
      end
      // Break flags: a new hit wins over the clear made by start.
      if (brk_set) begin
        brk_ff <= 1'b1;
      end else if (is_start) begin
        brk_ff <= 1'b0;
      end
      if (sw_set) begin
        swbrk_ff <= 1'b1;
      end else if (is_start) begin
        swbrk_ff <= 1'b0;
      end
      if (hw_set) begin
        hwbrk_ff <= 1'b1;
      end else if (is_start) begin
        hwbrk_ff <= 1'b0;
      end
      // The pc is frozen at the break so the probe reads where it stopped.
      if (brk_set) pc_hold_ff <= pc_i;
      mem_rd_ff <= mem_evt && (run_ff == RS_HALT);
      if (mem_evt) mem_addr_ff <= mem_upd_ff;
      if (mem_rd_ff) mem_data_ff <= mem_rdata_i;
      status_core_ff <= {4'h0, hwbrk_ff, swbrk_ff, brk_ff, run_ff == RS_HALT};
      state_core_ff <= {mem_data_ff, mem_addr_ff, pc_hold_ff};
    end
  end

  always_ff @(posedge clk_i) begin
    if (bk_evt) bk_addr_ff[bk_upd_ff[ADDR_W +: BIDX_W]] <= bk_upd_ff[ADDR_W-1:0];
  end

  // Only the instruction stream is gated; peripherals keep their own clock.
  assign cpu_run_o = (run_ff != RS_HALT);
  assign cpu_exec_pending_o = (run_ff == RS_PEND) || (run_ff == RS_STEP);
  assign mem_rd_o = mem_rd_ff;
  assign mem_addr_o = mem_addr_ff;
endmodule

// *** verilog/ocdbk_pkg.sv ***
package ocdbk_pkg;
  // TAP instruction register width and codes.
  localparam int IR_W = 4;
  localparam logic [3:0] IR_BYPASS = 4'hf;
  localparam logic [3:0] IR_IDCODE = 4'h1;
  localparam logic [3:0] IR_STATUS = 4'h8;
  localparam logic [3:0] IR_BKPT = 4'h9;
  localparam logic [3:0] IR_CTRL = 4'ha;
  localparam logic [3:0] IR_STATE = 4'hb;
  localparam logic [3:0] IR_MEM = 4'hc;
  // Control register command codes.
  localparam logic [1:0] CMD_NONE = 2'h0;
  localparam logic [1:0] CMD_STOP = 2'h1;
  localparam logic [1:0] CMD_START = 2'h2;
  localparam logic [1:0] CMD_STEP = 2'h3;
  // Breakpoint data register layout: address, index, enable.
  localparam int ADDR_W = 16;
  localparam int NUM_BKPT = 5;
  localparam int BIDX_W = 3;
  localparam int BKPT_DR_W = ADDR_W + BIDX_W + 1;
  // Status register layout.
  localparam int STAT_W = 8;
  localparam int STAT_HALT = 0;
  localparam int STAT_BREAK = 1;
  localparam int STAT_SWBRK = 2;
  localparam int STAT_HWBRK = 3;
  // State read-out register: pc, access address, data.
  localparam int DATA_W = 8;
  localparam int STATE_DR_W = ADDR_W + ADDR_W + DATA_W;
  localparam logic [31:0] IDCODE_VAL = 32'h0000_0001;  // Value is arbitrary.
  typedef enum logic [3:0] {
    TS_RESET = 4'h0, TS_IDLE = 4'h1, TS_SEL_DR = 4'h2, TS_CAP_DR = 4'h3,
    TS_SH_DR = 4'h4, TS_EX1_DR = 4'h5, TS_PA_DR = 4'h6, TS_EX2_DR = 4'h7,
    TS_UPD_DR = 4'h8, TS_SEL_IR = 4'h9, TS_CAP_IR = 4'ha, TS_SH_IR = 4'hb,
    TS_EX1_IR = 4'hc, TS_PA_IR = 4'hd, TS_EX2_IR = 4'he, TS_UPD_IR = 4'hf
  } ocdbk_tap_t;
  typedef enum logic [1:0] {
    RS_RUN = 2'h0, RS_HALT = 2'h1, RS_PEND = 2'h2, RS_STEP = 2'h3
  } ocdbk_run_t;
endpackage
